// ==== logic/tpg_gate_control.sv ====
// top of the three-phase gate control block
// assumes all pins synchronous to clk; analog parts sit outside
`timescale 1ns/100ps
`include "tpg_map.svh"
module tpg_gate_control (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire tpg_pkg::tpg_pair_type pwm_in,
  input  wire logic                  pwm_mode_three,
  input  wire logic                  gate_enable,
  input  wire logic [3:0]            dead_time_set_pin,
  input  wire tpg_pkg::tpg_pair_type trip_level_input,
  input  wire tpg_pkg::tpg_pair_type gate_off_ack,
  input  wire logic                  overcurrent_mode_select,
  input  wire logic                  fault_condition,
  input  wire logic                  overtemp_warning,
  input  wire logic                  gain_select,
  input  wire logic                  offset_cal_select,
  output tpg_pkg::tpg_pair_type      gate_out,
  output logic                       fault_out_n_o,
  output logic                       fault_out_n_oe_n,
  output logic                       warning_out_n_o,
  output logic                       warning_out_n_oe_n,
  output logic [7:0]                 amp_gain,
  output logic                       amp_inputs_shorted,
  output logic                       amp_load_connected,
  output logic                       quick_reset
);
  import tpg_pkg::*;
  logic [2:0]  want_high;
  logic [2:0]  want_low;
  logic [2:0]  trip_ev;
  logic        latch_q;
  logic        block;
  logic [9:0]  warn_cnt_q;
  logic [6:0]  low_cnt_q;
  logic        en_q;
  logic [3:0]  dead_cyc;
  logic        any_edge;
  logic [2:0]  high_q;

  // each channel maps its own inputs; mode pins read as static levels
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pwm_mode_three) begin
        want_high[i] = pwm_in.high[i];
        want_low[i]  = ~pwm_in.high[i];
      end else begin
        want_high[i] = pwm_in.high[i];
        want_low[i]  = pwm_in.low[i];
      end
    end
  end

  // grounded setting gives the minimum; clamp to 1 to 5 cycles (100 to 500 ns) against the documented 50 to 500 ns
  always_comb begin
    if (dead_time_set_pin < 4'(`TPG_DT_MIN_CYC)) begin
      dead_cyc = 4'(`TPG_DT_MIN_CYC);
    end else if (dead_time_set_pin > 4'(`TPG_DT_MAX_CYC)) begin
      dead_cyc = 4'(`TPG_DT_MAX_CYC);
    end else begin
      dead_cyc = dead_time_set_pin;
    end
  end

  assign block = ~gate_enable | fault_condition | latch_q;

  for (genvar c = 0; c < 3; c++) begin : g_ch
    tpg_channel u_ch (
      .clk          (clk),
      .arst_n       (arst_n),
      .want_high    (want_high[c]),
      .want_low     (want_low[c]),
      .block        (block),
      .dead_cyc     (dead_cyc),
      .high_off_ack (gate_off_ack.high[c]),
      .low_off_ack  (gate_off_ack.low[c]),
      .trip_high    (trip_level_input.high[c]),
      .trip_low     (trip_level_input.low[c]),
      .high_gate    (gate_out.high[c]),
      .low_gate     (gate_out.low[c]),
      .trip_event   (trip_ev[c])
    );
  end

  // enable low time measured; a short low pulse is a quick reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q      <= 1'b0;
      low_cnt_q <= 7'h00;
    end else begin
      en_q <= gate_enable;
      if (gate_enable) begin
        low_cnt_q <= 7'h00;
      end else if (low_cnt_q != 7'h7F) begin
        low_cnt_q <= low_cnt_q + 7'h01;
      end
    end
  end
  assign quick_reset = gate_enable & ~en_q & (low_cnt_q <= 7'(`TPG_QRST_CYC));

  // latched shutdown holds until the enable goes low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= 1'b0;
    end else if (overcurrent_mode_select & (|trip_ev)) begin
      latch_q <= 1'b1;
    end else if (!gate_enable) begin
      latch_q <= 1'b0;
    end
  end

  // warning stretch restarts on a new trip, ends on next pwm cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      high_q <= 3'h0;
    end else begin
      high_q <= pwm_in.high;
    end
  end
  assign any_edge = |(pwm_in.high & ~high_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warn_cnt_q <= 10'h000;
    end else if (!overcurrent_mode_select & (|trip_ev)) begin
      warn_cnt_q <= 10'(`TPG_WARN_CYC);
    end else if (any_edge | ~gate_enable) begin
      warn_cnt_q <= 10'h000;
    end else if (warn_cnt_q != 10'h000) begin
      warn_cnt_q <= warn_cnt_q - 10'h001;
    end
  end

  // open drain: only ever drive low, enable is active low while driving
  assign fault_out_n_o      = 1'b0;
  assign fault_out_n_oe_n   = ~(fault_condition | latch_q);
  assign warning_out_n_o    = 1'b0;
  assign warning_out_n_oe_n = ~((warn_cnt_q != 10'h000) | overtemp_warning);

  assign amp_gain           = gain_select ? `TPG_GAIN_HIGH : `TPG_GAIN_LOW;
  // calibration has no interlock with switching by design
  assign amp_inputs_shorted = offset_cal_select;
  assign amp_load_connected = ~offset_cal_select;
endmodule

// ==== logic/tpg_map.svh ====
// constants for the three-phase gate control block
// assumes a 10 MHz clock (100 ns period)
// Function
// - three channels, each high and low gate
// - six-input truth table per channel
// - three-input mode ignores low input
// - dead time 50 to 500 ns (code clamps the setting to 1 to 5 cycles, 100 to 500 ns)
// - dead time from falling to opposite rising
// - handshake: one gate off before other on
// - enable low or fault holds gates off
// - error drives gates low, fault low quickly
// - short enable low pulse clears all faults
// - trip compare only while transistor enabled
// - mode selects limit or latched shutdown
// - limit: off till next cycle, warn 64us
// - active-low open-drain fault and warning outputs
// - gain select low 10, high 40
// - calibration shorts inputs, disconnects load
// - calibration allowed any time
`ifndef TPG_MAP_SVH
`define TPG_MAP_SVH
`define TPG_CLK_NS        100
`define TPG_DT_MIN_NS     50
`define TPG_DT_MAX_NS     500
`define TPG_DT_MIN_CYC    ((`TPG_DT_MIN_NS + `TPG_CLK_NS - 1) / `TPG_CLK_NS)
`define TPG_DT_MAX_CYC    (`TPG_DT_MAX_NS / `TPG_CLK_NS)
`define TPG_ERR_NS        200
`define TPG_ERR_CYC       (`TPG_ERR_NS / `TPG_CLK_NS)
`define TPG_WARN_US       64
`define TPG_WARN_CYC      ((`TPG_WARN_US * 1000) / `TPG_CLK_NS)
`define TPG_QRST_US       10
`define TPG_QRST_CYC      ((`TPG_QRST_US * 1000) / `TPG_CLK_NS)
`define TPG_GAIN_LOW      8'h0A
`define TPG_GAIN_HIGH     8'h28
`endif

// ==== logic/tpg_pkg.sv ====
// types for the three-phase gate control block
// assumes tpg_map.svh for numbers
package tpg_pkg;
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } tpg_pair_type;
  typedef enum logic [3:0] {
    TPG_OFF     = 4'h1,
    TPG_DEAD    = 4'h2,
    TPG_HIGH_ON = 4'h4,
    TPG_LOW_ON  = 4'h8
  } tpg_state_type;
endpackage

// ==== logic/tpg_channel.sv ====
// one half-bridge channel: dead time, handshake and trip handling
// assumes inputs synchronous to clk and a static dead-time count
`timescale 1ns/100ps
`include "tpg_map.svh"
module tpg_channel (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       want_high,
  input  wire logic       want_low,
  input  wire logic       block,
  input  wire logic [3:0] dead_cyc,
  input  wire logic       high_off_ack,
  input  wire logic       low_off_ack,
  input  wire logic       trip_high,
  input  wire logic       trip_low,
  output logic            high_gate,
  output logic            low_gate,
  output logic            trip_event
);
  import tpg_pkg::*;
  tpg_state_type st_q;
  logic [3:0]    cnt_q;
  logic          next_high_q;
  logic          hi_cut_q;
  logic          lo_cut_q;
  logic          want_high_q;
  logic          want_low_q;
  logic          req_high;
  logic          req_low;
  logic          edge_high;
  logic          edge_low;

  // a new pwm edge on either input starts a new cycle
  assign edge_high = want_high & ~want_high_q;
  assign edge_low  = want_low & ~want_low_q;
  assign req_high  = want_high & ~want_low & ~hi_cut_q;
  assign req_low   = want_low & ~want_high & ~lo_cut_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      want_high_q <= 1'b0;
      want_low_q  <= 1'b0;
    end else begin
      want_high_q <= want_high;
      want_low_q  <= want_low;
    end
  end

  // tripped transistor stays off until the next pwm edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cut_q <= 1'b0;
      lo_cut_q <= 1'b0;
    end else begin
      // a block (enable low or fault) resets the driver, so the cutoff goes too
      if (trip_high & high_gate) begin
        hi_cut_q <= 1'b1;
      end else if (edge_high | edge_low | block) begin
        hi_cut_q <= 1'b0;
      end
      if (trip_low & low_gate) begin
        lo_cut_q <= 1'b1;
      end else if (edge_high | edge_low | block) begin
        lo_cut_q <= 1'b0;
      end
    end
  end

  // sensing only counts while the gate is on
  assign trip_event = (trip_high & high_gate) | (trip_low & low_gate);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q        <= TPG_OFF;
      cnt_q       <= 4'h0;
      next_high_q <= 1'b0;
    end else if (block) begin
      st_q <= TPG_OFF;
      cnt_q <= 4'h0;
    end else begin
      case (st_q)
        TPG_OFF: begin
          // wait for both gates confirmed off before timing dead time
          if ((req_high | req_low) & high_off_ack & low_off_ack) begin
            st_q        <= TPG_DEAD;
            cnt_q       <= dead_cyc;
            next_high_q <= req_high;
          end
        end
        TPG_DEAD: begin
          if ((next_high_q & ~req_high) | (~next_high_q & ~req_low)) begin
            st_q <= TPG_OFF;
          end else if (cnt_q <= 4'h1) begin
            st_q <= next_high_q ? TPG_HIGH_ON : TPG_LOW_ON;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        TPG_HIGH_ON: begin
          if (!req_high) begin
            st_q <= TPG_OFF;
          end
        end
        TPG_LOW_ON: begin
          if (!req_low) begin
            st_q <= TPG_OFF;
          end
        end
        default: begin
          st_q <= TPG_OFF;
        end
      endcase
    end
  end

  // gates drop combinationally so a block acts at once; a trip acts a cycle later through the registered cutoff
  assign high_gate = (st_q == TPG_HIGH_ON) & req_high & ~block;
  assign low_gate  = (st_q == TPG_LOW_ON) & req_low & ~block;
endmodule

// ==== sim/tpg_fets.sv ====
// model of the six external transistors on the gate pins
// assumes active-high gates; oc_cmd comes from the bench
`timescale 1ns/100ps
module tpg_fets (
  input  wire tpg_pkg::tpg_pair_type gate,
  input  wire tpg_pkg::tpg_pair_type oc_cmd,
  output tpg_pkg::tpg_pair_type      ack,
  output tpg_pkg::tpg_pair_type      trip
);
  import tpg_pkg::*;
  // a transistor reports off as soon as its gate is low
  assign ack = tpg_pair_type'(~gate);
  // an off transistor never shows an overload, whatever the bench asks
  assign trip = tpg_pair_type'(gate & oc_cmd);
endmodule

// ==== sim/tpg_gate_control_asserts.sv ====
// port checker for the gate control top
// assumes the bind at the foot of this file
`timescale 1ns/100ps
module tpg_gate_control_asserts (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire tpg_pkg::tpg_pair_type pwm_in,
  input wire logic                  pwm_mode_three,
  input wire logic                  gate_enable,
  input wire logic                  fault_condition,
  input wire logic                  overtemp_warning,
  input wire logic                  gain_select,
  input wire logic                  offset_cal_select,
  input wire tpg_pkg::tpg_pair_type gate_out,
  input wire logic                  fault_out_n_o,
  input wire logic                  fault_out_n_oe_n,
  input wire logic                  warning_out_n_oe_n,
  input wire logic                  warning_out_n_o,
  input wire logic [7:0]            amp_gain,
  input wire logic                  amp_inputs_shorted,
  input wire logic                  amp_load_connected
);
  import tpg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_gate_block: assert property (!gate_enable |-> gate_out == 6'h00)
    else $error("gates on while disabled");
  a_fault_off: assert property (
    fault_condition |-> gate_out == 6'h00 ##[0:2] (!fault_out_n_oe_n && !fault_out_n_o))
    else $error("fault did not stop gates");
  a_no_shoot: assert property ((gate_out.high & gate_out.low) == 3'h0)
    else $error("both gates of a channel on");
  // one cycle is the shortest dead gap at this clock
  a_dead_gap: assert property (
    ((gate_out.high & $past(gate_out.low)) | (gate_out.low & $past(gate_out.high))) == 3'h0)
    else $error("no dead gap");
  a_six_map: assert property (
    !pwm_mode_three |->
      ((gate_out.high & ~(pwm_in.high & ~pwm_in.low)) | (gate_out.low & ~(pwm_in.low & ~pwm_in.high))) == 3'h0)
    else $error("six-input map broken");
  a_three_map: assert property (
    pwm_mode_three |-> ((gate_out.high & ~pwm_in.high) | (gate_out.low & pwm_in.high)) == 3'h0)
    else $error("three-input map broken");
  a_gain_map: assert property (amp_gain == (gain_select ? 8'h28 : 8'h0A))
    else $error("wrong gain");
  a_cal_path: assert property (offset_cal_select |-> amp_inputs_shorted && !amp_load_connected)
    else $error("calibration path wrong");
  a_warn_temp: assert property (overtemp_warning |-> ##[0:2] !warning_out_n_oe_n && !warning_out_n_o)
    else $error("warning pin not pulled");
  c_high_on: cover property (gate_out.high[0] && !pwm_mode_three);
  c_warn: cover property ($fell(warning_out_n_oe_n));
  c_fault: cover property ($fell(fault_out_n_oe_n));
endmodule
bind tpg_gate_control tpg_gate_control_asserts tpg_gate_control_asserts_inst (.clk, .arst_n, .pwm_in,
  .pwm_mode_three, .gate_enable, .fault_condition, .overtemp_warning, .gain_select, .offset_cal_select,
  .gate_out, .fault_out_n_o, .fault_out_n_oe_n, .warning_out_n_oe_n, .warning_out_n_o, .amp_gain, .amp_inputs_shorted,
  .amp_load_connected);

// ==== sim/tb_tpg_gate_control.sv ====
// self-checking bench for the gate control top
// assumes the transistor model and the bound checker
`timescale 1ns/100ps
module tb_tpg_gate_control;
  import tpg_pkg::*;
  logic clk = 0, arst_n = 0, m3 = 0, en = 0, ocm = 0, flt = 0, otw = 0, gsel = 0, cal = 0;
  logic fo, foe, wo, woe, sh, ld, qr;
  logic [3:0] dt = 4'h5;
  logic [7:0] gain;
  logic [31:0] rs = 32'h2;
  tpg_pair_type pwm = '0, oc = '0, go, ack, trip;
  int fails = 0, comparisons = 0, cyc = 0, n, d;
  initial forever #50 clk = ~clk;
  tpg_gate_control tpg_gate_control_inst (.clk, .arst_n, .pwm_in(pwm), .pwm_mode_three(m3), .gate_enable(en),
    .dead_time_set_pin(dt), .trip_level_input(trip), .gate_off_ack(ack), .overcurrent_mode_select(ocm),
    .fault_condition(flt), .overtemp_warning(otw), .gain_select(gsel), .offset_cal_select(cal), .gate_out(go),
    .fault_out_n_o(fo), .fault_out_n_oe_n(foe), .warning_out_n_o(wo), .warning_out_n_oe_n(woe), .amp_gain(gain),
    .amp_inputs_shorted(sh), .amp_load_connected(ld), .quick_reset(qr));
  tpg_fets tpg_fets_inst (.gate(go), .oc_cmd(oc), .ack, .trip);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic tpg_pair_type exp_g(tpg_pair_type p, logic t);
    exp_g.high = t ? p.high : p.high & ~p.low;
    exp_g.low = t ? ~p.high : p.low & ~p.high;
  endfunction
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // about 1150 cycles are needed; 3000, over twice that, means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      finish_test;
    end
  end
  initial begin
    tick(6);
    arst_n = 1;
    en = 1;
    tick(2);
    for (int i = 0; i < 40; i++) begin
      rs = xs(rs);
      m3 = i[0];
      pwm = i == 0 ? 6'h3F : rs[5:0];
      tick(10);
      chk({2'h0, go}, {2'h0, exp_g(pwm, m3)});
    end
    $display("truth tables done");
    m3 = 1;
    for (int k = 0; k < 3; k++) begin
      dt = k == 0 ? 4'h0 : (k == 1 ? 4'h2 : 4'h5);
      d = dt == 0 ? 1 : int'(dt);
      pwm = '0;
      tick(10);
      pwm.high = 3'h7;
      n = 0;
      while (go.high[0] !== 1'b1 && n < 20) begin
        tick(1);
        n++;
      end
      chk(8'(n >= d && n < 20), 8'h01);
    end
    $display("dead time done");
    ocm = 0;
    oc.high[1] = 1;
    tick(3);
    chk({woe, go.high}, 8'h05);
    oc = '0;
    tick(600);
    chk({woe, go.high}, 8'h05);
    tick(45);
    chk({woe, go.high}, 8'h0D);
    oc.high[0] = 1;
    tick(3);
    oc = '0;
    pwm.high = 3'h0;
    tick(2);
    pwm.high = 3'h7;
    tick(10);
    chk({woe, go.high}, 8'h0F);
    $display("current limit done");
    ocm = 1;
    oc.high[2] = 1;
    tick(3);
    oc = '0;
    tick(5);
    chk({foe, go}, 8'h00);
    en = 0;
    tick(1);
    // enable low releases the latched fault but keeps every gate off
    chk({foe, go}, 8'h40);
    tick(3);
    en = 1;
    n = 0;
    // the pulse stands only until the next rising edge, so look before it
    #1;
    repeat (4) begin
      n += int'(qr);
      tick(1);
    end
    chk(8'(n), 8'h01);
    tick(10);
    chk({foe, go.high}, 8'h0F);
    flt = 1;
    tick(3);
    chk({foe, go}, 8'h00);
    flt = 0;
    $display("shutdown done");
    for (int k = 0; k < 4; k++) begin
      {gsel, cal} = 2'(k);
      otw = k[0];
      tick(2);
      chk(gain, gsel ? 8'h28 : 8'h0A);
      chk({sh, ld, woe, fo, wo}, {cal, ~cal, ~otw, 2'h0});
    end
    $display("amplifier done");
    finish_test;
  end
endmodule
